// File: aip_consts.vh
// Purpose: Shared constants for the amplifier I2C register port
// Assumes: Included by aip_i2c_regport.v only
// Notes:   Offsets are subaddresses; one byte per register
`ifndef AIP_CONSTS_VH
`define AIP_CONSTS_VH

// Chip address: first five bits sent, then two strap bits, then R/W
`define AIP_ADDR_PREFIX   5'h05
// Register file extent
`define AIP_NUM_REGS      12
`define AIP_NUM_REGS_B    8'h0C
`define AIP_TOP_SUB       8'h0B
// Register offsets
`define AIP_REG_PWR       8'h00
`define AIP_REG_GAIN      8'h01
`define AIP_REG_VOL       8'h03
`define AIP_REG_STAT      8'h0A
// Field positions
`define AIP_PWR_DOWN_BIT  0
`define AIP_PWR_MUTE_BIT  1
// Reset values
`define AIP_PWR_RST       8'h01
`define AIP_VOL_RST       8'h40
`define AIP_OTHER_RST     8'h00
// Volume code 0 is +24 dB, each step -0.375 dB, last code near -70 dB
`define AIP_VOL_MAX       8'hFA

`endif

// File: aip_i2c_master.sv
// Purpose: Behavioural I2C master for the register port
// Assumes: A released SDA reads as the pull-up level
// Notes:   SCL idles high between frames
`timescale 1ns/10ps
module aip_i2c_master (
  // Clock and resolved data wire
  input  wire logic clk_i,
  input  wire logic sda_i,
  // Drives, high releases
  output logic      scl_o,
  output logic      sda_o
);
  // Bus idle at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start or repeated start
  task automatic st();
    sda_o <= 1'b1;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    sda_o <= 1'b0;
    tk(3);
    scl_o <= 1'b0;
    tk(2);
  endtask
  // Stop, ends every frame
  task automatic sp();
    sda_o <= 1'b0;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    sda_o <= 1'b1;
    tk(3);
  endtask
  // One bit, data steady while SCL high
  task automatic bx(input logic b, output logic r);
    sda_o <= b;
    tk(3);
    scl_o <= 1'b1;
    tk(2);
    r = sda_i;
    tk(2);
    scl_o <= 1'b0;
    tk(2);
  endtask
  // Byte out MSB first, then ack slot
  task automatic wb(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bx(v[i], r);
    bx(1'b1, r);
    ack = !r;
  endtask
  // Byte in, master ack unless last
  task automatic rb(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bx(1'b1, v[i]);
    bx(last, r);
  endtask
endmodule // aip_i2c_master

// File: aip_i2c_regport.v
// Purpose: I2C slave control port and gain controls of an audio amplifier
// Assumes: SCL and SDA are synchronous to clk_i and far slower than it
// Notes:   SDA is open drain; sda_oe_o high pulls the line low
//
// Summary of operation
// [RULE_01] Acknowledge every accepted byte by pulling SDA low on ninth clock.
// [RULE_02] Write frame: start, address+W, ack, subaddress, ack, data, stop.
// [RULE_03] Burst write advances the subaddress pointer after every data byte.
// [RULE_04] Master loads the pointer by writing the subaddress before reading.
// [RULE_05] Master then sends repeated start and address with read bit set.
// [RULE_06] On read address match, drive register data out MSB first.
// [RULE_07] Master acks each wanted read byte, ends with nack and stop.
// [RULE_08] Address bits sent are 0,0,1,0,1, two strap bits, then R/W.
// [RULE_09] Strap level gives the two bits: 00, 01, 10, 11 in order.
// [RULE_10] Two-bit analog gain field at bits 1:0 picks full-scale mapping.
// [RULE_11] Digital volume in 0.375 dB steps from +24 dB down to -70 dB.
// [RULE_12] Controller mutes or powers down before stopping the audio clock.
// [RULE_13] Start or stop out of sequence abandons the transfer at once.
// [RULE_14] Unknown subaddress gets no acknowledge and the port goes idle.
// [RULE_15] Burst read past the top keeps returning the top register.
// [RULE_16] Burst write past the top is discarded, nacked, port goes idle.
// [RULE_17] Commit a written byte after its acknowledge, then advance pointer.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "aip_consts.vh"

module aip_i2c_regport (
  // Clock and reset
  input  wire       clk_i,
  input  wire       resetn_i,
  // I2C pins
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  // Address strap level, 0 pull-down .. 3 tied to logic supply
  input  wire [1:0] addr_strap_level_i,
  // Local register port
  input  wire [7:0] host_addr_i,
  input  wire [7:0] host_wdata_i,
  input  wire       host_we_i,
  input  wire       host_re_i,
  output reg  [7:0] host_rdata_o,
  // Amplifier controls
  output wire [1:0] analog_gain_select_o,
  output wire [7:0] volume_code_o,
  output wire       power_down_o,
  output wire       mute_o
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_SUB  = 3'd2;
  localparam [2:0] ST_WR   = 3'd3;
  localparam [2:0] ST_RD   = 3'd4;

  reg  [1:0] rst_sync_q;
  wire       rst_n;
  reg        strap_done_q;
  reg  [1:0] strap_q;
  reg        scl_q;
  reg        sda_q;
  reg        scl_prev_q;
  reg        sda_prev_q;
  reg  [2:0] state_q;
  reg  [2:0] next_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg        ack_q;
  reg        mack_q;
  reg  [7:0] ptr_q;
  reg  [7:0] wr_data_q;
  reg  [7:0] wr_addr_q;
  reg        wr_req_q;
  reg  [7:0] regs_q [0:`AIP_NUM_REGS-1];
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire [7:0] tx_byte;
  integer    i;

  //////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Read value of a subaddress; status is live, unmapped reads zero
  function [7:0] rd_val;
    input [7:0] idx;
    begin
      if (idx == `AIP_REG_STAT) begin
        rd_val = {5'h00, strap_q, (state_q != ST_IDLE)};
      end else if (idx < `AIP_NUM_REGS_B) begin
        rd_val = regs_q[idx[3:0]];
      end else begin
        rd_val = 8'h00;
      end
    end
  endfunction

  // Value stored on a write; volume is held inside its range
  function [7:0] wr_fix;
    input [7:0] idx;
    input [7:0] val;
    begin
      if (idx == `AIP_REG_VOL && val > `AIP_VOL_MAX) begin
        wr_fix = `AIP_VOL_MAX; // see [RULE_11]
      end else begin
        wr_fix = val;
      end
    end
  endfunction

  // Reset value of each register
  function [7:0] rst_val;
    input integer idx;
    begin
      if (idx == 0) begin
        rst_val = `AIP_PWR_RST;
      end else if (idx == 3) begin
        rst_val = `AIP_VOL_RST;
      end else begin
        rst_val = `AIP_OTHER_RST;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release and strap capture

  // Two-stage release of the asynchronous reset
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Strap level caught once, in the first cycle after release
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      strap_q      <= 2'b00;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= addr_strap_level_i; // see [RULE_09]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus line sampling and condition detection

  // Previous line levels for edge and condition detection
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_q      <= scl_i;
      sda_q      <= sda_i;
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise   = scl_q & ~scl_prev_q;
  assign scl_fall   = ~scl_q & scl_prev_q;
  assign start_cond = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_cond  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
  assign tx_byte    = rd_val(ptr_q);

  //////////////////////////////////////////////////////////////////////////
  // Protocol state machine

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      next_q    <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ack_q     <= 1'b0;
      mack_q    <= 1'b0;
      ptr_q     <= 8'h00;
      wr_data_q <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_req_q  <= 1'b0;
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else begin
      wr_req_q <= 1'b0;
      sda_o    <= 1'b0;
      if (start_cond) begin
        // Start, repeated or not, always begins a new address byte
        state_q   <= ST_ADDR; // see [RULE_13]
        bit_cnt_q <= 4'h0;
        ack_q     <= 1'b0;
        mack_q    <= 1'b0;
        sda_oe_o  <= 1'b0;
      end else if (stop_cond) begin
        state_q  <= ST_IDLE; // see [RULE_13]
        ack_q    <= 1'b0;
        mack_q   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_SUB, ST_WR: begin
            if (scl_rise && !ack_q && bit_cnt_q != 4'h8) begin
              shift_q   <= {shift_q[6:0], sda_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && !ack_q && bit_cnt_q == 4'h8) begin
              // Byte complete: accept and ack, or drop to idle
              if (state_q == ST_ADDR) begin
                if (shift_q[7:3] == `AIP_ADDR_PREFIX &&
                    shift_q[2:1] == strap_q) begin // see [RULE_08]
                  sda_oe_o <= 1'b1; // see [RULE_01]
                  ack_q    <= 1'b1;
                  next_q   <= shift_q[0] ? ST_RD : ST_SUB;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_SUB) begin
                if (shift_q < `AIP_NUM_REGS_B) begin
                  ptr_q    <= shift_q; // see [RULE_02]
                  sda_oe_o <= 1'b1;
                  ack_q    <= 1'b1;
                  next_q   <= ST_WR;
                end else begin
                  state_q <= ST_IDLE; // see [RULE_14]
                end
              end else begin
                if (ptr_q < `AIP_NUM_REGS_B) begin
                  wr_data_q <= shift_q;
                  sda_oe_o  <= 1'b1;
                  ack_q     <= 1'b1;
                  next_q    <= ST_WR;
                end else begin
                  state_q <= ST_IDLE; // see [RULE_16]
                end
              end
            end else if (scl_fall && ack_q) begin
              // End of the ack slot: release, commit, move on
              ack_q     <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= next_q;
              if (state_q == ST_WR) begin
                wr_req_q  <= 1'b1; // see [RULE_17]
                wr_addr_q <= ptr_q;
                ptr_q     <= ptr_q + 8'h01; // see [RULE_03]
              end
              if (next_q == ST_RD) begin
                shift_q  <= tx_byte; // see [RULE_06]
                sda_oe_o <= ~tx_byte[7];
              end else begin
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (scl_rise && !mack_q) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && !mack_q) begin
              if (bit_cnt_q == 4'h8) begin
                sda_oe_o <= 1'b0; // free the line for the master ack
                mack_q   <= 1'b1;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0}; // see [RULE_06]
                sda_oe_o <= ~shift_q[6];
              end
            end else if (scl_rise && mack_q) begin
              if (sda_q) begin
                state_q <= ST_IDLE; // master nack ends the read
                mack_q  <= 1'b0;
              end else if (ptr_q != `AIP_TOP_SUB) begin
                ptr_q <= ptr_q + 8'h01;
              end // see [RULE_15]
            end else if (scl_fall && mack_q) begin
              mack_q    <= 1'b0;
              bit_cnt_q <= 4'h0;
              shift_q   <= tx_byte;
              sda_oe_o  <= ~tx_byte[7];
            end
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file and local port

  // I2C commits take priority over a local write in the same cycle
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `AIP_NUM_REGS; i = i + 1) begin
        regs_q[i] <= rst_val(i);
      end
    end else if (wr_req_q) begin
      if (wr_addr_q != `AIP_REG_STAT && wr_addr_q < `AIP_NUM_REGS_B) begin
        regs_q[wr_addr_q[3:0]] <= wr_fix(wr_addr_q, wr_data_q);
      end
    end else if (host_we_i) begin
      if (host_addr_i != `AIP_REG_STAT && host_addr_i < `AIP_NUM_REGS_B) begin
        regs_q[host_addr_i[3:0]] <= wr_fix(host_addr_i, host_wdata_i);
      end
    end
  end

  // Local read data stand for exactly one cycle after the strobe
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_o <= 8'h00;
    end else if (host_re_i) begin
      host_rdata_o <= rd_val(host_addr_i);
    end else begin
      host_rdata_o <= 8'h00;
    end
  end

  // Controls taken straight from register bits
  assign analog_gain_select_o = regs_q[1][1:0]; // see [RULE_10]
  assign volume_code_o        = regs_q[3]; // see [RULE_11]
  assign power_down_o         = regs_q[0][`AIP_PWR_DOWN_BIT];
  assign mute_o               = regs_q[0][`AIP_PWR_MUTE_BIT];

endmodule // aip_i2c_regport

// File: aip_i2c_regport_asserts.sv
// Purpose: Port checks for the amplifier I2C register port
// Assumes: One clock domain, reset active low
// Notes:   Bound to every aip_i2c_regport
`timescale 1ns/10ps
module aip_i2c_regport_asserts (
  // Clock, reset, pins
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // Local port, controls
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic       host_we_i,
  input wire logic       host_re_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic [1:0] analog_gain_select_o,
  input wire logic [7:0] volume_code_o,
  input wire logic       power_down_o,
  input wire logic       mute_o
);
  logic       scl_q, sda_q;
  logic [4:0] cnt_q, cnt_d;
  wire        start_w = scl_i && scl_q && sda_q && !sda_i;
  // Count SCL rises since the last start
  assign cnt_d = start_w ? 5'h00 :
    (scl_i && !scl_q && cnt_q != 5'h1F) ? cnt_q + 5'h01 : cnt_q;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 5'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od)
    else $error("sda_o high");
  property p_ack; $rose(sda_oe_o) |-> cnt_q >= 5'h08; endproperty
  a_ack: assert property (p_ack)
    else $error("drive before byte end");
  property p_turn; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_turn: assert property (p_turn)
    else $error("sda change in scl high");
  property p_quiet; start_w |=> !sda_oe_o [*8]; endproperty
  a_quiet: assert property (p_quiet)
    else $error("drive after start");
  property p_vmax; volume_code_o <= 8'hFA; endproperty
  a_vmax: assert property (p_vmax)
    else $error("volume above range");
  property p_rdv;
    host_re_i && host_addr_i == 8'h03 |=> host_rdata_o == volume_code_o;
  endproperty
  a_rdv: assert property (p_rdv)
    else $error("volume readback");
  property p_wrg;
    host_we_i && host_addr_i == 8'h01 |=>
      {6'h00, analog_gain_select_o} == ($past(host_wdata_i) & 8'h03);
  endproperty
  a_wrg: assert property (p_wrg)
    else $error("gain write");
  property p_wrp;
    host_we_i && host_addr_i == 8'h00 |=>
      {6'h00, mute_o, power_down_o} == ($past(host_wdata_i) & 8'h03);
  endproperty
  a_wrp: assert property (p_wrp)
    else $error("power write");
  c_ack: cover property ($rose(sda_oe_o));
  c_start: cover property (start_w);
  c_read: cover property (host_re_i);
endmodule // aip_i2c_regport_asserts

bind aip_i2c_regport aip_i2c_regport_asserts u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .host_we_i(host_we_i),
  .host_re_i(host_re_i), .host_rdata_o(host_rdata_o),
  .analog_gain_select_o(analog_gain_select_o),
  .volume_code_o(volume_code_o), .power_down_o(power_down_o),
  .mute_o(mute_o));

// File: aip_i2c_regport_tb.sv
// Purpose: Self-checking bench for the I2C register port
// Assumes: Master model on SDA/SCL, bench on the local port
// Notes:   mdl mirrors the register map
`timescale 1ns/10ps
module aip_i2c_regport_tb;
  logic        clk_i, resetn_i, scl, msda, sda_o, sda_oe_o;
  logic        we, re, ack, pd, mute;
  logic [1:0]  strap, gain;
  logic [7:0]  adr, wd, rd, vol, d;
  logic [7:0]  mdl [12];
  logic [7:0]  q [$];
  logic [31:0] seed = 32'd44;
  int          n_mismatch = 0;
  int          num_checks = 0;
  wire         sda_w = msda & ~sda_oe_o; // Pull-up wire
  aip_i2c_master u_m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_o(msda));
  aip_i2c_regport u_aip_i2c_regport (.clk_i(clk_i), .resetn_i(resetn_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .addr_strap_level_i(strap), .host_addr_i(adr), .host_wdata_i(wd),
    .host_we_i(we), .host_re_i(re), .host_rdata_o(rd),
    .analog_gain_select_o(gain), .volume_code_o(vol), .power_down_o(pd),
    .mute_o(mute));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic ck8(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t byte %h exp %h", $time, g, e);
    end
  endtask
  task automatic ck1(input logic g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t bit %b exp %b", $time, g, e);
    end
  endtask
  // Model commit, volume clamped
  task automatic put(input int a, input logic [7:0] v);
    if (a < 12 && a != 10) mdl[a] = (a == 3 && v > 8'hFA) ? 8'hFA : v;
  endtask
  task automatic outs();
    ck8(vol, mdl[3]);
    ck8({6'h00, gain}, mdl[1] & 8'h03);
    ck1(pd, mdl[0][0]);
    ck1(mute, mdl[0][1]);
  endtask
  // Burst write of q from sub
  task automatic iw(input int p);
    u_m.st();
    u_m.wb({5'h05, strap, 1'b0}, ack);
    ck1(ack, 1'b1);
    u_m.wb(p[7:0], ack);
    ck1(ack, p < 12);
    foreach (q[i]) begin
      u_m.wb(q[i], ack);
      ck1(ack, p < 12);
      put(p, q[i]);
      p++;
    end
    u_m.sp();
    outs();
  endtask
  // Burst read of n bytes from sub
  task automatic ir(input int p, input int n);
    u_m.st();
    u_m.wb({5'h05, strap, 1'b0}, ack);
    u_m.wb(p[7:0], ack);
    u_m.st();
    u_m.wb({5'h05, strap, 1'b1}, ack);
    ck1(ack, 1'b1);
    for (int i = 1; i <= n; i++) begin
      u_m.rb(i == n, d);
      ck8(d, mdl[p]);
      if (p < 11) p++;
    end
    u_m.sp();
  endtask
  task automatic hw(input logic [7:0] a, v);
    adr <= a;
    wd <= v;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
    put(a, v);
    @(posedge clk_i);
  endtask
  task automatic hr(input logic [7:0] a, e);
    adr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 ck8(rd, e);
    @(posedge clk_i);
  endtask
  task automatic rst(input logic [1:0] s);
    resetn_i <= 1'b0;
    strap <= s;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[0] = 8'h01;
    mdl[3] = 8'h40;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {resetn_i, strap, we, re, adr, wd} = '0;
    for (int s = 0; s < 4; s++) begin
      rst(s[1:0]);
      outs();
      u_m.st();
      u_m.wb({5'h05, strap ^ 2'h1, 1'b0}, ack);
      ck1(ack, 1'b0);
      u_m.sp();
      q = {rnd(), rnd(), rnd() & 8'h7F};
      iw(1);
      ir(1, 3);
    end
    q = {rnd(), rnd(), rnd()};
    iw(11);
    ir(11, 3);
    iw(12);
    // Stop in mid data byte: later clocks must not finish that byte
    u_m.st();
    u_m.wb({5'h05, strap, 1'b0}, ack);
    u_m.wb(8'h03, ack);
    repeat (4) u_m.bx(1'b0, ack);
    u_m.sp();
    repeat (5) u_m.bx(1'b1, ack);
    ck1(ack, 1'b1);
    u_m.sp();
    outs();
    for (int c = 0; c < 4; c++) begin
      hw(8'h01, (rnd() & 8'hFC) | c[7:0]);
      outs();
    end
    hw(8'h03, 8'hFF);
    hw(8'h00, 8'h02);
    outs();
    for (int a = 0; a < 12; a++)
      if (a != 10) hr(a[7:0], mdl[a]);
    hr(8'h20, 8'h00);
    // Status is read only and shows the captured strap, port idle
    hw(8'h0A, rnd());
    hr(8'h0A, {5'h00, strap, 1'b0});
    end_sim();
  end
  // Watchdog, about five times the expected run
  initial begin
    #300000;
    n_mismatch++;
    end_sim();
  end
endmodule // aip_i2c_regport_tb
